// file: core/swc_period_counter.sv
// Free-running period counter with clear, giving one pulse per period
`timescale 1ns/10ps
module swc_period_counter #(
  parameter int unsigned     WIDTH = 22,
  parameter logic [WIDTH-1:0] LIMIT = 22'd2250000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  logic [WIDTH-1:0] count;
  wire              at_end = (count == LIMIT - WIDTH'(1));

  assign tick_o = run_i & at_end;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      count <= '0;
    end else if (at_end) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule

// file: core/swc_pkg.sv
// Constants, register map and carrier types for the sleep and watchdog control block
package swc_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WDT_PERIOD_NS = 18000000;
  localparam int unsigned WDT_BASE_CYC  = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WDT_BASE_W    = 22;
  localparam int unsigned PRESCALE_W    = 7;
  localparam int unsigned RATIO_W       = 3;

  // Register byte addresses
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_OPTION = 8'h04;
  localparam logic [7:0] ADR_INTCTL = 8'h08;
  localparam logic [7:0] ADR_PERIPH = 8'h0c;

  // Values after reset, and the writable bits of the peripheral register
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] PERIPH_MSK = 8'h33;

  // Field positions
  localparam int unsigned ST_EXPIRY_N = 4;
  localparam int unsigned ST_PWRDN_N  = 3;
  localparam int unsigned OPT_ASSIGN  = 3;
  localparam int unsigned OPT_PS_LSB  = 0;
  localparam int unsigned IC_GLB_EN   = 7;
  localparam int unsigned IC_T0IE     = 5;
  localparam int unsigned IC_INTE     = 4;
  localparam int unsigned IC_IOCE     = 3;
  localparam int unsigned IC_T0IF     = 2;
  localparam int unsigned IC_INTF     = 1;
  localparam int unsigned IC_IOCF     = 0;
  localparam int unsigned PR_TMR1IE   = 0;
  localparam int unsigned PR_ADIE     = 1;
  localparam int unsigned PR_TMR1IF   = 4;
  localparam int unsigned PR_ADIF     = 5;

  typedef enum logic {
    SWC_RUN,
    SWC_SLEEP
  } swc_state_t;

  typedef struct packed {
    logic halt;
    logic kick;
  } swc_core_ev_t;

  typedef struct packed {
    logic ext_int;
    logic pin_change;
    logic adc_done;
    logic tmr1_ovf;
    logic tmr1_async;
    logic tmr0_ovf;
  } swc_wake_src_t;

endpackage

// file: core/swc_prescaler.sv
// Binary prescaler dividing a tick stream by two to the ratio field
`timescale 1ns/10ps
module swc_prescaler #(
  parameter int unsigned CW = 7,
  parameter int unsigned RW = 3
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          clear_i,
  input  wire logic          bypass_i,
  input  wire logic          tick_i,
  input  wire logic [RW-1:0] ratio_i,
  output logic               tick_o
);
  logic [CW-1:0] count;
  wire  [CW-1:0] mask = CW'((1 << ratio_i) - 1);
  wire           wrap = ((count & mask) == mask);

  assign tick_o = tick_i & (bypass_i | wrap);

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count <= '0;
    end else if (tick_i) begin
      count <= wrap ? '0 : count + CW'(1);
    end
  end
endmodule

// file: core/swc_sleep_wdt.sv
// Power-down control and watchdog with a classic Wishbone register slave
//
// Overview of operation
// - Only the halt instruction enters power-down.
// - Entering power-down clears watchdog; keeps it counting.
// - Entering power-down clears powerdown flag, sets expiry flag.
// - Power-down gates no clock or analog enables.
// - I/O ports keep their state during power-down.
// - Non-watchdog resets act as in normal operation.
// - Reset pin resets; watchdog and interrupts wake.
// - Wake sources: async timer1, converter, pin change, edge; code also wakes on timer0.
// - Own enable gates wake; global enable does not.
// - After wake, vector only if global enable set.
// - Every wake-up clears the watchdog.
// - Halt with pending enabled interrupt is a no-operation.
// - Interrupt during or after halt wakes immediately.
// - Configuration bit enables watchdog; clear disables permanently.
// - Expiry resets when running, wakes when asleep.
// - Base period 18 ms, prescaler up to 1:128.
// - Kick or halt clears watchdog and assigned prescaler.
// - Watchdog expiry clears the expiry flag.
// - Prescaler assignment is software changeable anytime.
// - Interrupt flags set regardless of enable bits.
`timescale 1ns/10ps
module swc_sleep_wdt #(
  parameter int unsigned WDT_BASE_CYCLES = swc_pkg::WDT_BASE_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire swc_pkg::swc_core_ev_t  core_ev_i,
  input  wire swc_pkg::swc_wake_src_t wake_src_i,
  input  wire logic                   watchdog_config_enable_i,
  input  wire logic                   ext_reset_enable_i,
  input  wire logic                   external_reset_pin_n_i,
  output logic                        sleeping_o,
  output logic                        wake_o,
  output logic                        wake_vector_o,
  output logic                        device_reset_o
);

  swc_pkg::swc_state_t state;
  swc_pkg::swc_state_t next_state;

  logic [7:0] status_q;
  logic [7:0] option_q;
  logic [7:0] intctl_q;
  logic [7:0] periph_q;
  logic       wdt_en;

  // Bus decode
  wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0]  wdat    = wb_dat_i[7:0];
  wire        hit_st  = (wb_adr_i == swc_pkg::ADR_STATUS);
  wire        hit_opt = (wb_adr_i == swc_pkg::ADR_OPTION);
  wire        hit_ic  = (wb_adr_i == swc_pkg::ADR_INTCTL);
  wire        hit_pr  = (wb_adr_i == swc_pkg::ADR_PERIPH);
  wire [7:0]  rd_byte = hit_st  ? status_q :
                        hit_opt ? option_q :
                        hit_ic  ? intctl_q :
                        hit_pr  ? periph_q : 8'h00;

  // Wake sources: each gated by its own enable, timer1 also by tmr1_async; the global enable plays no part
  wire t0_pend   = intctl_q[swc_pkg::IC_T0IE] & intctl_q[swc_pkg::IC_T0IF];
  wire edge_pend = intctl_q[swc_pkg::IC_INTE] & intctl_q[swc_pkg::IC_INTF];
  wire ioc_pend  = intctl_q[swc_pkg::IC_IOCE] & intctl_q[swc_pkg::IC_IOCF];
  // Timer1 stops with the synchronous clock, so only an asynchronous counter may wake
  wire t1_pend   = periph_q[swc_pkg::PR_TMR1IE] & periph_q[swc_pkg::PR_TMR1IF]
                   & wake_src_i.tmr1_async;
  wire adc_pend  = periph_q[swc_pkg::PR_ADIE] & periph_q[swc_pkg::PR_ADIF];
  wire irq_pend  = t0_pend | edge_pend | ioc_pend | t1_pend | adc_pend;

  // Watchdog chain
  logic base_tick;
  logic pre_tick;
  wire  assign_wdt  = option_q[swc_pkg::OPT_ASSIGN];
  wire  wdt_expire  = wdt_en & pre_tick;
  wire  is_run      = (state == swc_pkg::SWC_RUN);
  wire  is_sleep    = (state == swc_pkg::SWC_SLEEP);
  wire  ext_reset   = ext_reset_enable_i & ~external_reset_pin_n_i;
  wire  run_expire  = is_run & wdt_expire & ~ext_reset;
  // A pending enabled interrupt turns the halt into a no-operation
  wire  sleep_entry = is_run & core_ev_i.halt & ~irq_pend & ~run_expire & ~ext_reset;
  wire  wake        = is_sleep & (irq_pend | wdt_expire) & ~ext_reset;
  // Kick clears too; a halt taken as no-operation clears nothing
  wire  wdt_clear   = (is_run & core_ev_i.kick) | sleep_entry | wake | run_expire
                      | ext_reset;
  wire  pre_clear   = (wdt_clear & assign_wdt) | ~wdt_en;

  // Cycles since the last watchdog clear, read only by the period check
  logic [31:0] since_clear;

  always_ff @(posedge clk_i) begin
    if (rst_i || wdt_clear || !wdt_en) begin
      since_clear <= 32'h0000_0000;
    end else begin
      since_clear <= since_clear + 32'h0000_0001;
    end
  end

  swc_period_counter #(
    .WIDTH (swc_pkg::WDT_BASE_W),
    .LIMIT (swc_pkg::WDT_BASE_W'(WDT_BASE_CYCLES))
  ) u_base (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (wdt_en),
    .clear_i (wdt_clear),
    .tick_o  (base_tick)
  );

  swc_prescaler #(
    .CW (swc_pkg::PRESCALE_W),
    .RW (swc_pkg::RATIO_W)
  ) u_pre (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (pre_clear),
    .bypass_i (~assign_wdt),
    .tick_i   (base_tick),
    .ratio_i  (option_q[swc_pkg::OPT_PS_LSB +: swc_pkg::RATIO_W]),
    .tick_o   (pre_tick)
  );

  // Status: the two flags are hardware owned, the other bits belong to the core
  wire [7:0] st_base = (bus_wr & hit_st) ?
                       {wdat[7:5], status_q[4:3], wdat[2:0]} : status_q;
  wire       next_expiry_n = wdt_expire ? 1'b0 :
                             sleep_entry ? 1'b1 : st_base[swc_pkg::ST_EXPIRY_N];
  wire       next_pwrdn_n  = sleep_entry ? 1'b0 : st_base[swc_pkg::ST_PWRDN_N];
  wire [7:0] next_status   = {st_base[7:5], next_expiry_n, next_pwrdn_n, st_base[2:0]};

  // Flags: a hardware set in the same cycle as a software clear wins
  wire [7:0] ic_base  = (bus_wr & hit_ic) ? wdat : intctl_q;
  wire [7:0] ic_set   = (8'(wake_src_i.tmr0_ovf) << swc_pkg::IC_T0IF)
                        | (8'(wake_src_i.ext_int) << swc_pkg::IC_INTF)
                        | (8'(wake_src_i.pin_change) << swc_pkg::IC_IOCF);
  wire [7:0] next_ic  = ic_base | ic_set;
  wire [7:0] pr_base  = (bus_wr & hit_pr) ? (wdat & swc_pkg::PERIPH_MSK) : periph_q;
  wire [7:0] pr_set   = (8'(wake_src_i.tmr1_ovf) << swc_pkg::PR_TMR1IF)
                        | (8'(wake_src_i.adc_done) << swc_pkg::PR_ADIF);
  wire [7:0] next_pr  = pr_base | pr_set;
  wire [7:0] next_opt = (bus_wr & hit_opt) ? wdat : option_q;

  always_comb begin
    next_state = state;
    case (state)
      swc_pkg::SWC_RUN: begin
        if (sleep_entry) begin
          next_state = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        if (wake || ext_reset) begin
          next_state = swc_pkg::SWC_RUN;
        end
      end
      default: begin
        next_state = swc_pkg::SWC_RUN;
      end
    endcase
  end

  // Configuration bit is caught while reset is held; nothing turns it on again later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_en <= watchdog_config_enable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= swc_pkg::SWC_RUN;
      status_q <= swc_pkg::STATUS_RST;
      option_q <= swc_pkg::OPTION_RST;
      intctl_q <= swc_pkg::INTCTL_RST;
      periph_q <= swc_pkg::PERIPH_RST;
    end else begin
      state    <= next_state;
      status_q <= next_status;
      option_q <= next_opt;
      intctl_q <= next_ic;
      periph_q <= next_pr;
    end
  end

  // Power-down drives only the sleeping_o level: clocks, analog enables and pads stay as they are
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleeping_o     <= 1'b0;
      wake_o         <= 1'b0;
      wake_vector_o  <= 1'b0;
      device_reset_o <= 1'b0;
    end else begin
      sleeping_o     <= (next_state == swc_pkg::SWC_SLEEP);
      wake_o         <= wake;
      wake_vector_o  <= wake & irq_pend & intctl_q[swc_pkg::IC_GLB_EN];
      device_reset_o <= ext_reset | run_expire;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_halt_only;
    $rose(sleeping_o) |-> $past(core_ev_i.halt);
  endproperty
  a_halt_only: assert property (p_halt_only) else $error("power-down entered without halt");

  property p_sleep_flags;
    sleep_entry |=> status_q[swc_pkg::ST_PWRDN_N] == 1'b0 && sleeping_o
                    && (status_q[swc_pkg::ST_EXPIRY_N] == 1'b1 || $past(wdt_expire));
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("flags wrong after entry");

  property p_halt_nop;
    is_run && core_ev_i.halt && irq_pend && !ext_reset && !wdt_expire
      |=> !sleeping_o && $stable(status_q[4:3]);
  endproperty
  a_halt_nop: assert property (p_halt_nop) else $error("pending halt not a no-operation");

  property p_irq_wake;
    is_sleep && irq_pend && !ext_reset |=> wake_o && !sleeping_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("pending interrupt did not wake");

  property p_wdt_run_reset;
    run_expire |=> device_reset_o && !status_q[swc_pkg::ST_EXPIRY_N] && !sleeping_o;
  endproperty
  a_wdt_run_reset: assert property (p_wdt_run_reset) else $error("expiry did not reset");

  property p_wdt_sleep_wake;
    is_sleep && wdt_expire && !ext_reset |=> wake_o && !device_reset_o
                                            && !status_q[swc_pkg::ST_EXPIRY_N];
  endproperty
  a_wdt_sleep_wake: assert property (p_wdt_sleep_wake) else $error("expiry did not wake");

  property p_wdt_disabled;
    !wdt_en && is_sleep && !irq_pend |=> !wake_o;
  endproperty
  a_wdt_disabled: assert property (p_wdt_disabled) else $error("disabled watchdog woke");

  property p_vector_needs_glb;
    wake_vector_o |-> wake_o && $past(intctl_q[swc_pkg::IC_GLB_EN]);
  endproperty
  a_vector_needs_glb: assert property (p_vector_needs_glb) else $error("vector without global enable");

  property p_flag_set;
    wake_src_i.ext_int |=> intctl_q[swc_pkg::IC_INTF];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge flag not set");

  property p_reset_pin;
    ext_reset |=> device_reset_o && !sleeping_o;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");

  property p_wake_clears;
    wake |=> !wdt_expire;
  endproperty
  a_wake_clears: assert property (p_wake_clears) else $error("watchdog not cleared on wake");

  c_enter_sleep: cover property (sleep_entry);
  c_irq_wake:    cover property (is_sleep && irq_pend);
  c_wdt_wake:    cover property (is_sleep && wdt_expire);
  // Clearing, wake causes, flag setting and the period floor
  property p_kick_clears;
    is_run && core_ev_i.kick |=> !wdt_expire;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear watchdog");

  property p_entry_clears;
    sleep_entry |=> is_sleep && !wdt_expire;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("entry did not clear watchdog");

  property p_wake_pd;
    wake |=> !status_q[swc_pkg::ST_PWRDN_N] && !sleeping_o;
  endproperty
  a_wake_pd: assert property (p_wake_pd) else $error("powerdown flag wrong after wake");

  property p_no_cause;
    is_sleep && !irq_pend && !wdt_expire && !ext_reset |=> !wake_o && sleeping_o;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("woke without a cause");

  property p_own_enable;
    is_sleep && irq_pend && !intctl_q[swc_pkg::IC_GLB_EN] && !ext_reset |=> wake_o && !wake_vector_o;
  endproperty
  a_own_enable: assert property (p_own_enable) else $error("wake needed global enable");

  property p_ioc_flag;
    wake_src_i.pin_change |=> intctl_q[swc_pkg::IC_IOCF];
  endproperty
  a_ioc_flag: assert property (p_ioc_flag) else $error("pin change flag not set");

  property p_adc_flag;
    wake_src_i.adc_done |=> periph_q[swc_pkg::PR_ADIF];
  endproperty
  a_adc_flag: assert property (p_adc_flag) else $error("converter flag not set");

  property p_tmr0_flag;
    wake_src_i.tmr0_ovf |=> intctl_q[swc_pkg::IC_T0IF];
  endproperty
  a_tmr0_flag: assert property (p_tmr0_flag) else $error("timer0 flag not set");

  property p_status_ro;
    bus_wr && hit_st && !sleep_entry && !wdt_expire |=> $stable(status_q[4:3]);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status flags written by bus");

  property p_bypass;
    !assign_wdt |-> pre_tick == base_tick;
  endproperty
  a_bypass: assert property (p_bypass) else $error("prescaler not bypassed");

  property p_period_floor;
    wdt_expire |-> since_clear >= WDT_BASE_CYCLES - 1;
  endproperty
  a_period_floor: assert property (p_period_floor) else $error("watchdog expired early");

  c_halt_nop:    cover property (is_run && core_ev_i.halt && irq_pend);
  c_vector:      cover property (wake_vector_o);

endmodule

// file: testbench/swc_core_model.sv
// Behavioural core issuing halt and watchdog-kick instruction events
`timescale 1ns/10ps
module swc_core_model (
  input  wire logic             clk_i,
  input  wire logic             sleeping_i,
  output swc_pkg::swc_core_ev_t core_ev_o
);
  initial core_ev_o = '0;

  // A halted core fetches nothing, so it issues no event while asleep
  task automatic exec(input bit is_halt);
    @(posedge clk_i);
    if (sleeping_i !== 1'b1) begin
      core_ev_o.halt <= is_halt;
      core_ev_o.kick <= !is_halt;
    end
    @(posedge clk_i);
    core_ev_o <= '0;
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the sleep and watchdog control block
`timescale 1ns/10ps
module testbench;
  localparam int unsigned N = 16;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cyc = 1'b0;
  logic                   stb = 1'b0;
  logic                   we = 1'b0;
  logic [7:0]             adr = 8'h00;
  logic [31:0]            dat = 32'h0;
  logic [3:0]             sel = 4'h1;
  logic [31:0]            dat_o;
  logic                   ack;
  swc_pkg::swc_wake_src_t src = '0;
  swc_pkg::swc_core_ev_t  core_ev;
  logic                   cfg_en = 1'b1;
  logic                   rpin_en = 1'b1;
  logic                   rpin_n = 1'b1;
  logic                   sleeping, wake, vec, dev_rst;
  logic                   w_seen, v_seen, d_seen;
  logic [7:0]             q, q0;
  int                     n_errors = 0;
  int                     cmp_count = 0;
  int                     rst_seen = 0;
  int                     n, r0;
  logic [7:0] c_en [6] = '{8'h10, 8'h08, 8'h02, 8'h01, 8'h01, 8'h00};
  logic       c_per [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic       c_glb [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic       c_asy [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic       c_wk [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int         c_bit [6] = '{5, 4, 3, 2, 2, 5};
  logic [7:0] c_opt [4] = '{8'h08, 8'h09, 8'h0b, 8'h07};
  int         c_len [4] = '{N, 2 * N, 8 * N, N};

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (dev_rst === 1'b1) rst_seen++;

  swc_core_model core (.clk_i(clk_i), .sleeping_i(sleeping), .core_ev_o(core_ev));

  swc_sleep_wdt #(.WDT_BASE_CYCLES(N)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .core_ev_i(core_ev),
    .wake_src_i(src), .watchdog_config_enable_i(cfg_en), .ext_reset_enable_i(rpin_en),
    .external_reset_pin_n_i(rpin_n), .sleeping_o(sleeping), .wake_o(wake), .wake_vector_o(vec),
    .device_reset_o(dev_rst));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until ack is seen high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = dat_o[7:0];
    check("dat hi", 0, {8'h00, dat_o[31:8]});
    check("ack", 1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(what, exp, q);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i);
    src[b] <= 1'b1;
    @(posedge clk_i);
    src[b] <= 1'b0;
  endtask

  task automatic wait_ev(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wake !== 1'b1 && dev_rst !== 1'b1 && k < 3000);
    w_seen = wake;
    v_seen = vec;
    d_seen = dev_rst;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("MISMATCH run length expected finish seen hang");
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("status rst", 8'h00, swc_pkg::STATUS_RST);
    rd("option rst", 8'h04, swc_pkg::OPTION_RST);
    rd("intctl rst", 8'h08, swc_pkg::INTCTL_RST);
    rd("periph rst", 8'h0c, swc_pkg::PERIPH_RST);
    sel <= 4'h0;
    wb(1'b1, 8'h04, 8'h00);
    sel <= 4'h1;
    rd("sel off", 8'h04, swc_pkg::OPTION_RST);
    wb(1'b1, 8'h00, 8'h00);
    rd("status ro", 8'h00, 8'h18);
    wb(1'b1, 8'h0c, 8'hff);
    rd("periph mask", 8'h0c, swc_pkg::PERIPH_MSK);
    wb(1'b1, 8'h10, 8'hff);
    rd("unmapped", 8'h10, 8'h00);
    // Wake sources, enables and vectoring; unwoken cases leave by watchdog
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 8'h08, {c_glb[i], 7'h0} | (c_per[i] ? 8'h00 : c_en[i]));
      wb(1'b1, 8'h0c, c_per[i] ? c_en[i] : 8'h00);
      src.tmr1_async <= c_asy[i];
      core.exec(1'b0);
      core.exec(1'b1);
      repeat (2) @(posedge clk_i);
      check("sleeping", 1, sleeping);
      rd("status asleep", 8'h00, 8'h10);
      pulse(c_bit[i]);
      wait_ev(n);
      check("wake", 1, w_seen);
      check("vector", c_glb[i] & c_wk[i], v_seen);
      check("irq wake", c_wk[i], n <= 4);
      rd("status woke", 8'h00, c_wk[i] ? 8'h10 : 8'h00);
    end
    src.tmr1_async <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, 8'h04, c_opt[p]);
      core.exec(1'b0);
      wait_ev(n);
      check("expiry reset", 1, d_seen);
      check("period", 1, n >= c_len[p] && n <= c_len[p] + 2);
    end
    wb(1'b1, 8'h04, 8'h08);
    r0 = rst_seen;
    repeat (12) begin
      core.exec(1'b0);
      repeat (8) @(posedge clk_i);
    end
    check("kicked", r0, rst_seen);
    core.exec(1'b1);
    wait_ev(n);
    check("wdt wake", 1, w_seen && n >= N && n <= N + 2);
    wb(1'b1, 8'h04, 8'hff);
    wb(1'b1, 8'h08, 8'h00);
    pulse(0);
    rd("flag no enable", 8'h08, 8'h04);
    wb(1'b1, 8'h08, 8'h24);
    wb(1'b0, 8'h00, 8'h00);
    q0 = q;
    core.exec(1'b1);
    repeat (2) @(posedge clk_i);
    check("noop sleep", 0, sleeping);
    rd("noop status", 8'h00, q0);
    wb(1'b1, 8'h08, 8'h10);
    fork
      core.exec(1'b1);
      pulse(5);
    join
    wait_ev(n);
    check("late irq", 1, w_seen && n <= 4);
    rd("late status", 8'h00, 8'h10);
    wb(1'b1, 8'h08, 8'h00);
    core.exec(1'b1);
    rpin_n <= 1'b0;
    wait_ev(n);
    check("pin reset", 1, d_seen && n <= 3);
    @(posedge clk_i);
    check("pin wakes", 0, sleeping);
    rpin_n <= 1'b1;
    rd("pin status", 8'h00, 8'h10);
    rpin_en <= 1'b0;
    r0 = rst_seen;
    rpin_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("pin off", r0, rst_seen);
    rpin_n <= 1'b1;
    cfg_en <= 1'b0;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h04, 8'h08);
    r0 = rst_seen;
    core.exec(1'b1);
    repeat (100) @(posedge clk_i);
    check("wdt off sleep", 1, sleeping);
    check("wdt off", r0, rst_seen);
    report_and_stop();
  end
endmodule
